// ### design/dct_top.sv
// Dual counter/timer control: narrow and wide counters, register file, interrupts
//
// Contract
// - Bit 7 runs or stops each counter
// - Modulo mode reloads from hold at terminal count
// - Single-pass mode halts at terminal count, except the wide counter in demod
// - Demod bit 6 gates wide counter edges
// - Bit 5 timeout flag, write one clears
// - Timeout flags set at every terminal count
// - Ping-pong alternates run bits at terminal count
// - Bits 4:3 select clock divide 1/2/4/8
// - Bit 2 enables capture interrupt
// - Wide bit 1 enables timeout interrupt
// - Wide bit 0 routes output to pin
// - Double-default fields survive stop-mode recovery
// - Wide control bits 5:2 survive recovery
// - Hold registers at offsets 04, 05, 06, 07
// - Wide and narrow counters raise separate requests
// - Reset values zero, aux three 1f
`timescale 1ns/1ns
module dct_top (
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic stop_wake_recovery,
  // Register port
  input wire dct_pkg::dct_bus_s bus,
  output logic [7:0] rdata,
  // Demodulation edge input and port data for the shared pin
  input wire logic demod_in,
  input wire logic port_out_bit,
  // Pins and requests
  output logic shared_timer_pin,
  output logic wide_timeout_request,
  output logic narrow_timeout_request,
  output logic irq
);
  import dct_pkg::*;

  // Software-visible control, hold and capture registers
  logic [7:0] nctl_r;
  logic [7:0] aux1_r;
  logic [7:0] wctl_r;
  logic [7:0] aux3_r;
  logic [7:0] mode_r;
  logic [7:0] nhl_r;
  logic [7:0] nhh_r;
  logic [7:0] whl_r;
  logic [7:0] whh_r;
  logic [7:0] wcl_r;
  logic [7:0] wch_r;
  logic [7:0] ncl_r;
  logic [7:0] nch_r;
  // Interrupt status and mask
  logic [IRQ_W-1:0] ist_r;
  logic [IRQ_W-1:0] imk_r;
  // Down counters and their output toggles
  logic [7:0] ncnt_r;
  logic [15:0] wcnt_r;
  logic nout_r;
  logic wout_r;
  // Demodulation input synchroniser stages
  logic din_m_r;
  logic din_s_r;
  logic din_d_r;
  // Registered read data
  logic [7:0] rdata_r;
  // Count ticks, terminal counts and edge strobe
  logic n_tick;
  logic w_tick;
  logic n_tc;
  logic w_tc;
  logic edge_seen;
  // Run-bit control and mode decode
  logic n_halt;
  logic w_halt;
  logic ping;
  // Interrupt events and control-register write decodes
  logic [IRQ_W-1:0] ev;
  logic wr_n;
  logic wr_w;

  // Mode decode and control-register write strobes
  assign ping = (mode_r[1:0] == MODE_PING);
  assign wr_n = bus.wr && (bus.addr == NCTL_OFF);
  assign wr_w = bus.wr && (bus.addr == WCTL_OFF);

  // Prescalers, one per counter
  dct_prescale u_npre (
    .clk(clk),
    .resetn(resetn),
    .run(nctl_r[RUN_BIT]),
    .sel(nctl_r[CLK_HI:CLK_LO]),
    .tick(n_tick)
  );
  dct_prescale u_wpre (
    .clk(clk),
    .resetn(resetn),
    .run(wctl_r[RUN_BIT]),
    .sel(wctl_r[CLK_HI:CLK_LO]),
    .tick(w_tick)
  );

  // Terminal count when a counter at one is ticked
  assign n_tc = n_tick && (ncnt_r == 8'h01);
  assign w_tc = w_tick && (wcnt_r == 16'h0001);
  // Halt in single pass outside ping-pong; the wide counter also does not halt in demod
  // Ping-pong owns the run bits, so single pass does not halt there
  assign n_halt = n_tc && nctl_r[SGL_BIT] && !ping;
  assign w_halt = w_tc && wctl_r[SGL_BIT] && !ping && (mode_r[1:0] != MODE_DEMOD);

  // Demodulation input synchroniser and edge detector
  // Only the second and third stages feed logic; the first may be metastable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
      din_d_r <= 1'b0;
    end else begin
      din_m_r <= demod_in;
      din_s_r <= din_m_r;
      din_d_r <= din_s_r;
    end
  end
  assign edge_seen = (din_s_r ^ din_d_r) && !wctl_r[SGL_BIT];

  // Narrow counter: reload from hold at terminal count or when stopped
  // Stopped counters preload the hold of the phase they resume in,
  // so the first count after enable is a full half period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ncnt_r <= HOLD_RST;
      nout_r <= 1'b0;
    end else if (!nctl_r[RUN_BIT]) begin
      ncnt_r <= nout_r ? nhh_r : nhl_r;
    end else if (n_tc) begin
      nout_r <= ~nout_r;
      ncnt_r <= nout_r ? nhl_r : nhh_r;
    end else if (n_tick) begin
      ncnt_r <= ncnt_r - 8'h01;
    end
  end

  // Wide counter: counts down in transmit, captures on edges in demod
  // An edge restarts the count so each capture holds one interval
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wcnt_r <= 16'h0000;
      wout_r <= 1'b0;
    end else if (!wctl_r[RUN_BIT]) begin
      wcnt_r <= {whh_r, whl_r};
    end else if (mode_r[1:0] == MODE_DEMOD && edge_seen) begin
      wcnt_r <= {whh_r, whl_r};
    end else if (w_tc) begin
      wout_r <= ~wout_r;
      wcnt_r <= {whh_r, whl_r};
    end else if (w_tick) begin
      wcnt_r <= wcnt_r - 16'h0001;
    end
  end

  // Capture registers: wide latches count on edges, narrow ones are written only by software
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wcl_r <= HOLD_RST;
      wch_r <= HOLD_RST;
      ncl_r <= HOLD_RST;
      nch_r <= HOLD_RST;
    end else begin
      if (wctl_r[RUN_BIT] && mode_r[1:0] == MODE_DEMOD && edge_seen) begin
        wcl_r <= wcnt_r[7:0];
        wch_r <= wcnt_r[15:8];
      end else begin
        if (bus.wr && bus.addr == WCL_OFF) begin
          wcl_r <= bus.wdata;
        end
        if (bus.wr && bus.addr == WCH_OFF) begin
          wch_r <= bus.wdata;
        end
      end
      if (bus.wr && bus.addr == NCL_OFF) begin
        ncl_r <= bus.wdata;
      end
      if (bus.wr && bus.addr == NCH_OFF) begin
        nch_r <= bus.wdata;
      end
    end
  end

  // Hold and auxiliary registers, plain read/write
  // Stop-mode recovery leaves holds alone and returns aux and mode fields
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nhl_r <= HOLD_RST;
      nhh_r <= HOLD_RST;
      whl_r <= HOLD_RST;
      whh_r <= HOLD_RST;
      aux1_r <= CTL_RST;
      aux3_r <= AUX3_RST;
      mode_r <= CTL_RST;
    end else if (stop_wake_recovery) begin
      aux1_r <= aux1_r & AUX1_KEEP;
      aux3_r <= AUX3_RST;
      mode_r <= CTL_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        NHL_OFF: nhl_r <= bus.wdata;
        NHH_OFF: nhh_r <= bus.wdata;
        WHL_OFF: whl_r <= bus.wdata;
        WHH_OFF: whh_r <= bus.wdata;
        AUX1_OFF: aux1_r <= bus.wdata;
        AUX3_OFF: aux3_r <= bus.wdata;
        MODE_OFF: mode_r <= {6'h00, bus.wdata[1:0]};
        default: ;
      endcase
    end
  end

  // Narrow control: software fields, hardware run hand-over and timeout flag
  // Hardware run changes follow the software write so they take priority
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nctl_r <= CTL_RST;
    end else if (stop_wake_recovery) begin
      nctl_r <= nctl_r & NCTL_KEEP;
    end else begin
      if (wr_n) begin
        nctl_r[RUN_BIT] <= bus.wdata[RUN_BIT];
        nctl_r[SGL_BIT] <= bus.wdata[SGL_BIT];
        nctl_r[CLK_HI:CLK_LO] <= bus.wdata[CLK_HI:CLK_LO];
        nctl_r[CAP_BIT] <= bus.wdata[CAP_BIT];
      end
      if (n_halt || (ping && n_tc)) nctl_r[RUN_BIT] <= 1'b0;
      if (ping && w_tc) nctl_r[RUN_BIT] <= 1'b1;
      // Set wins over write-one clear
      if (n_tc) begin
        nctl_r[TOF_BIT] <= 1'b1;
      end else if (wr_n && bus.wdata[TOF_BIT]) begin
        nctl_r[TOF_BIT] <= 1'b0;
      end
    end
  end

  // Wide control: same layout plus timeout mask and pin route
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wctl_r <= CTL_RST;
    end else if (stop_wake_recovery) begin
      wctl_r <= wctl_r & WCTL_KEEP;
    end else begin
      if (wr_w) begin
        wctl_r[RUN_BIT] <= bus.wdata[RUN_BIT];
        wctl_r[SGL_BIT] <= bus.wdata[SGL_BIT];
        wctl_r[CLK_HI:CLK_LO] <= bus.wdata[CLK_HI:CLK_LO];
        wctl_r[CAP_BIT] <= bus.wdata[CAP_BIT];
        wctl_r[TIE_BIT] <= bus.wdata[TIE_BIT];
        wctl_r[PIN_BIT] <= bus.wdata[PIN_BIT];
      end
      if (w_halt || (ping && w_tc)) wctl_r[RUN_BIT] <= 1'b0;
      if (ping && n_tc) wctl_r[RUN_BIT] <= 1'b1;
      if (w_tc) begin
        wctl_r[TOF_BIT] <= 1'b1;
      end else if (wr_w && bus.wdata[TOF_BIT]) begin
        wctl_r[TOF_BIT] <= 1'b0;
      end
    end
  end

  // Events: timeouts and captures
  // Capture events only reach status; the request pins carry timeouts
  always_comb begin
    ev = '0;
    ev[EV_NTO] = n_tc;
    ev[EV_WTO] = w_tc;
    ev[EV_NCAP] = n_tc && nctl_r[CAP_BIT];
    ev[EV_WCAP] = wctl_r[RUN_BIT] && (mode_r[1:0] == MODE_DEMOD) && edge_seen
                  && wctl_r[CAP_BIT];
  end

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ist_r <= '0;
      imk_r <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if (ev[i]) begin
          ist_r[i] <= 1'b1;
        end else if (bus.wr && bus.addr == IST_OFF && bus.wdata[i]) begin
          ist_r[i] <= 1'b0;
        end
      end
      if (bus.wr && bus.addr == IMK_OFF) begin
        imk_r <= bus.wdata[IRQ_W-1:0];
      end
    end
  end

  // Timeout requests in the cycle the flag sets, gated by masks
  assign wide_timeout_request = w_tc && wctl_r[TIE_BIT];
  assign narrow_timeout_request = n_tc && nctl_r[CAP_BIT];
  assign irq = |(ist_r & imk_r);

  // Shared pin: wide counter output or ordinary port data
  // Registered so the pin does not glitch when the route bit changes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shared_timer_pin <= 1'b0;
    end else begin
      shared_timer_pin <= wctl_r[PIN_BIT] ? wout_r : port_out_bit;
    end
  end

  // Read data, one cycle after the read strobe, zero otherwise
  // Idle cycles return zero so stale data is never taken for an answer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        NCTL_OFF: rdata_r <= nctl_r;
        AUX1_OFF: rdata_r <= aux1_r;
        WCTL_OFF: rdata_r <= wctl_r;
        AUX3_OFF: rdata_r <= aux3_r;
        NHL_OFF: rdata_r <= nhl_r;
        NHH_OFF: rdata_r <= nhh_r;
        WHL_OFF: rdata_r <= whl_r;
        WHH_OFF: rdata_r <= whh_r;
        WCL_OFF: rdata_r <= wcl_r;
        WCH_OFF: rdata_r <= wch_r;
        NCL_OFF: rdata_r <= ncl_r;
        NCH_OFF: rdata_r <= nch_r;
        IST_OFF: rdata_r <= {4'h0, ist_r};
        IMK_OFF: rdata_r <= {4'h0, imk_r};
        MODE_OFF: rdata_r <= mode_r;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign rdata = rdata_r;
endmodule : dct_top

// ### shared/dct_pkg.sv
// Package with register map, field positions and reset values of the dual counter/timer block
package dct_pkg;
  // Register offsets (bank D)
  localparam logic [3:0] NCTL_OFF = 4'h0;
  localparam logic [3:0] AUX1_OFF = 4'h1;
  localparam logic [3:0] WCTL_OFF = 4'h2;
  localparam logic [3:0] AUX3_OFF = 4'h3;
  localparam logic [3:0] NHL_OFF = 4'h4;
  localparam logic [3:0] NHH_OFF = 4'h5;
  localparam logic [3:0] WHL_OFF = 4'h6;
  localparam logic [3:0] WHH_OFF = 4'h7;
  localparam logic [3:0] WCL_OFF = 4'h8;
  localparam logic [3:0] WCH_OFF = 4'h9;
  localparam logic [3:0] NCL_OFF = 4'ha;
  localparam logic [3:0] NCH_OFF = 4'hb;
  localparam logic [3:0] IST_OFF = 4'hc;
  localparam logic [3:0] IMK_OFF = 4'hd;
  localparam logic [3:0] MODE_OFF = 4'he;
  // Control field positions
  localparam int RUN_BIT = 7;
  localparam int SGL_BIT = 6;
  localparam int TOF_BIT = 5;
  localparam int CLK_HI = 4;
  localparam int CLK_LO = 3;
  localparam int CAP_BIT = 2;
  localparam int TIE_BIT = 1;
  localparam int PIN_BIT = 0;
  // Reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] AUX3_RST = 8'h1f;
  localparam logic [7:0] HOLD_RST = 8'h00;
  // Fields kept across stop-mode recovery
  localparam logic [7:0] NCTL_KEEP = 8'h3c;
  localparam logic [7:0] WCTL_KEEP = 8'h3c;
  localparam logic [7:0] AUX1_KEEP = 8'h30;
  // Interrupt status bit layout
  localparam int IRQ_W = 4;
  localparam int EV_NTO = 0;
  localparam int EV_WTO = 1;
  localparam int EV_NCAP = 2;
  localparam int EV_WCAP = 3;
  // Operating mode encodings (mode register bits 1:0)
  localparam logic [1:0] MODE_TX = 2'h0;
  localparam logic [1:0] MODE_DEMOD = 2'h1;
  localparam logic [1:0] MODE_PING = 2'h2;

  // Register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dct_bus_s;
endpackage : dct_pkg

// ### design/dct_prescale.sv
// Count-clock tick generator dividing the system clock by 1, 2, 4 or 8
`timescale 1ns/1ns
module dct_prescale (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic run,
  input wire logic [1:0] sel,
  // Tick out
  output logic tick
);
  import dct_pkg::*;

  logic [2:0] div_r;

  // Free divider held at zero while stopped so each start is aligned
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= 3'h0;
    end else if (!run) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // Tick when the low sel bits of the divider are all ones
  always_comb begin
    unique case (sel)
      2'b00: tick = run;
      2'b01: tick = run & div_r[0];
      2'b10: tick = run & (&div_r[1:0]);
      2'b11: tick = run & (&div_r[2:0]);
    endcase
  end
endmodule : dct_prescale

// ### test/dct_checker.sv
// Port checker for the dual counter/timer block
`timescale 1ns/1ns
module dct_checker (
  // Clock and resets
  input wire logic clk,
  input wire logic resetn,
  input wire logic stop_wake_recovery,
  // Register port and pins
  input wire dct_pkg::dct_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic demod_in,
  input wire logic port_out_bit,
  input wire logic shared_timer_pin,
  input wire logic wide_timeout_request,
  input wire logic narrow_timeout_request,
  input wire logic irq
);
  import dct_pkg::*;
  logic [4:0] wctl_r;
  logic [4:2] nctl_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Shadow of software-written control bits; recovery drops the wide low bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wctl_r <= 5'h00;
      nctl_r <= 3'h0;
    end else begin
      if (bus.wr && bus.addr == WCTL_OFF) wctl_r <= bus.wdata[4:0];
      else if (stop_wake_recovery) wctl_r[1:0] <= 2'h0;
      if (bus.wr && bus.addr == NCTL_OFF) nctl_r <= bus.wdata[4:2];
    end
  end
  chk_hold_readback: assert property ((bus.wr && bus.addr == NHL_OFF) ##2
    (bus.rd && bus.addr == NHL_OFF) |=> rdata == $past(bus.wdata, 3))
    else $error("hold register readback wrong");
  chk_wide_mask: assert property (wide_timeout_request |-> wctl_r[TIE_BIT])
    else $error("wide request while masked");
  chk_narrow_mask: assert property (narrow_timeout_request |-> nctl_r[CAP_BIT])
    else $error("narrow request while masked");
  chk_pin_port: assert property (!$past(wctl_r[0]) |->
    shared_timer_pin == $past(port_out_bit))
    else $error("pin not following port data");
  chk_flag_after_tc: assert property (narrow_timeout_request ##1
    (bus.rd && bus.addr == NCTL_OFF) |=> rdata[TOF_BIT])
    else $error("timeout flag not set");
  chk_irq_masked: assert property (bus.wr && bus.addr == IMK_OFF &&
    bus.wdata == 8'h00 |=> !irq)
    else $error("interrupt high with mask clear");
  chk_wctl_keep: assert property (stop_wake_recovery ##2
    (bus.rd && bus.addr == WCTL_OFF) |=> rdata[4:2] == wctl_r[4:2] &&
    rdata[7:6] == 2'h0 && rdata[1:0] == 2'h0)
    else $error("wide control wrong after recovery");
  chk_nctl_keep: assert property (stop_wake_recovery ##2
    (bus.rd && bus.addr == NCTL_OFF) |=> rdata[4:2] == nctl_r && rdata[7:6] == 2'h0)
    else $error("narrow control wrong after recovery");
  chk_aux_recover: assert property (stop_wake_recovery ##2
    (bus.rd && bus.addr == AUX3_OFF) |=> rdata == AUX3_RST)
    else $error("aux three wrong after recovery");
endmodule : dct_checker

bind dct_top dct_checker dct_checker_i (.clk(clk), .resetn(resetn),
  .stop_wake_recovery(stop_wake_recovery), .bus(bus), .rdata(rdata), .demod_in(demod_in),
  .port_out_bit(port_out_bit), .shared_timer_pin(shared_timer_pin),
  .wide_timeout_request(wide_timeout_request),
  .narrow_timeout_request(narrow_timeout_request), .irq(irq));

// ### test/dct_top_tb.sv
// Self-checking testbench for the dual counter/timer block
`timescale 1ns/1ns
module dct_top_tb;
  import dct_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic stop_wake_recovery = 1'b0;
  dct_bus_s bus = '0;
  logic port_out_bit = 1'b0;
  logic demod_in = 1'b0;
  logic [7:0] rdata;
  logic shared_timer_pin, wide_timeout_request, narrow_timeout_request, irq;
  int errors = 0;
  int n_checks = 0;
  int n;
  logic w;
  logic [7:0] d;
  // Rows: address, value written, value read back
  logic [23:0] rows [11] = '{24'h04a5a5, 24'h055a5a, 24'h063c3c, 24'h07c3c3, 24'h092222,
    24'h0b4444, 24'h015a5a, 24'h030e0e, 24'h0d0505, 24'h0fff00, 24'h023c1c};
  // Clock and design
  always #2 clk = ~clk;
  dct_top dct_top_i (.clk(clk), .resetn(resetn), .stop_wake_recovery(stop_wake_recovery),
    .bus(bus), .rdata(rdata), .demod_in(demod_in), .port_out_bit(port_out_bit),
    .shared_timer_pin(shared_timer_pin), .wide_timeout_request(wide_timeout_request),
    .narrow_timeout_request(narrow_timeout_request), .irq(irq));
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data is taken once the answering edge has settled
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk({7'h0, irq}, {7'h0, e});
  endtask : chk_irq
  task automatic recover(input logic [3:0] a);
    @(posedge clk);
    stop_wake_recovery <= 1'b1;
    @(posedge clk);
    stop_wake_recovery <= 1'b0;
    rd(a);
  endtask : recover
  // Bounded wait for the next timeout request; n counts the cycles
  task automatic wait_pulse();
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        errors++;
        end_of_test();
      end
    end while (!(narrow_timeout_request | wide_timeout_request));
    w = wide_timeout_request;
  endtask : wait_pulse
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i][19:16], rows[i][15:8]);
      rd(rows[i][19:16]);
      chk(d, rows[i][7:0]);
    end
    // Reset in mid-run, then every register at its reset value
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 15; a++) begin
      rd(a[3:0]);
      chk(d, (a == 3) ? AUX3_RST : CTL_RST);
    end
    // Modulo counting at each prescale setting
    wr(NHL_OFF, 8'h03);
    wr(NHH_OFF, 8'h03);
    for (int s = 0; s < 4; s++) begin
      wr(NCTL_OFF, 8'h84 | 8'(s << 3));
      wait_pulse();
      wait_pulse();
      chk(8'(n), 8'(3 << s));
      rd(NCTL_OFF);
      chk(d, 8'ha4 | 8'(s << 3));
    end
    wr(NCTL_OFF, 8'h00);
    rd(NCTL_OFF);
    chk(d, 8'h20);
    wr(NCTL_OFF, 8'h20);
    rd(NCTL_OFF);
    chk(d, 8'h00);
    chk_irq(1'b0);
    // Single pass halts after one terminal count
    wr(NHL_OFF, 8'h02);
    wr(NHH_OFF, 8'h02);
    wr(NCTL_OFF, 8'hc4);
    wait_pulse();
    rd(NCTL_OFF);
    chk(d, 8'h64);
    n = 0;
    repeat (20) begin
      @(negedge clk);
      n += narrow_timeout_request;
    end
    chk(8'(n), 8'h00);
    // Wide counter timeout, interrupt raise, mask and clear
    wr(IST_OFF, 8'hff);
    wr(WHH_OFF, 8'h00);
    wr(WHL_OFF, 8'h04);
    wr(IMK_OFF, 8'h02);
    wr(WCTL_OFF, 8'h82);
    wait_pulse();
    chk({7'h0, w}, 8'h01);
    chk_irq(1'b1);
    wait_pulse();
    // One falling edge of this period went to the interrupt check
    chk(8'(n + 1), 8'h04);
    wr(WCTL_OFF, 8'h02);
    rd(IST_OFF);
    chk(d, 8'h02);
    wr(IMK_OFF, 8'h00);
    chk_irq(1'b0);
    wr(IMK_OFF, 8'h02);
    chk_irq(1'b1);
    wr(IST_OFF, 8'h02);
    chk_irq(1'b0);
    // Ping-pong hands over between the counters
    wr(MODE_OFF, {6'h00, MODE_PING});
    wr(NCTL_OFF, 8'h84);
    for (int i = 0; i < 4; i++) begin
      wait_pulse();
      chk({7'h0, w}, 8'(i % 2));
    end
    wr(MODE_OFF, {6'h00, MODE_TX});
    wr(NCTL_OFF, 8'h20);
    wr(WCTL_OFF, 8'h20);
    // Demodulation: an edge captures the count and reloads; bit 6 masks edges
    wr(IST_OFF, 8'hff);
    wr(WHH_OFF, 8'h01);
    wr(WHL_OFF, 8'h00);
    wr(MODE_OFF, {6'h00, MODE_DEMOD});
    wr(WCTL_OFF, 8'h84);
    @(posedge clk);
    demod_in <= 1'b1;
    repeat (4) @(posedge clk);
    // Hold 0x0100 less three ticks: one before the input rises and two sync stages
    rd(WCL_OFF);
    chk(d, 8'hfd);
    rd(WCH_OFF);
    chk(d, 8'h00);
    rd(IST_OFF);
    chk(d, 8'h08);
    wr(WCTL_OFF, 8'hc4);
    @(posedge clk);
    demod_in <= 1'b0;
    repeat (4) @(posedge clk);
    rd(WCL_OFF);
    chk(d, 8'hfd);
    wr(WCTL_OFF, 8'h20);
    wr(MODE_OFF, {6'h00, MODE_TX});
    // Stop-mode recovery keeps only the retained fields
    wr(WCTL_OFF, 8'h3f);
    wr(NCTL_OFF, 8'h1c);
    wr(AUX1_OFF, 8'hff);
    wr(AUX3_OFF, 8'h00);
    recover(WCTL_OFF);
    chk(d, 8'h1c);
    recover(NCTL_OFF);
    chk(d, 8'h1c);
    recover(AUX1_OFF);
    chk(d, 8'h30);
    recover(AUX3_OFF);
    chk(d, AUX3_RST);
    rd(NHL_OFF);
    chk(d, 8'h02);
    @(posedge clk);
    port_out_bit <= 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h0, shared_timer_pin}, 8'h01);
    end_of_test();
  end
endmodule : dct_top_tb
